// File: phy_mode_config_registers_tb_top.sv
// Purpose: Self-checking bench for the PHY mode configuration registers
// Assumes: Straps give mode 010, address 05; short energy idle time
// Notes: Only one PHY sits on the management bus
`default_nettype none
module phy_mode_config_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, prst = 1'b0, brst = 1'b0;
    logic energy_detect = 1'b0, loader_we = 1'b0, ok;
    logic [15:0] loader_data = 16'h0000, d, wd, rdata;
    logic mv, mw, ack, edpd, lep, an, s100, fd, crs, pd;
    logic [4:0] pa, ra, sa;
    logic [2:0] mode;
    logic [10:0] seed;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    pmc_regs #(.IDLE_CYCLES(20)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .port_reset_pulse(prst), .basic_ctrl_reset(brst),
        .autoneg_strap(1'b0), .speed_strap(1'b1), .duplex_strap(1'b0),
        .addr_strap(5'h05), .energy_detect(energy_detect),
        .loader_we(loader_we), .loader_data(loader_data), .mgmt_valid(mv),
        .mgmt_write(mw), .mgmt_phy_addr(pa), .mgmt_reg_addr(ra),
        .mgmt_wdata(wd), .mgmt_rdata(rdata), .mgmt_ack(ack),
        .energy_detect_powerdown_enable(edpd), .line_energy_present(lep),
        .phy_mode(mode), .phy_station_address(sa), .autoneg_enable(an),
        .speed_100(s100), .full_duplex(fd), .crs_on_transmit(crs),
        .power_down(pd), .scrambler_seed(seed));
    pmc_host host (.clk(clk), .mgmt_ack(ack), .mgmt_rdata(rdata),
        .mgmt_valid(mv), .mgmt_write(mw), .mgmt_phy_addr(pa),
        .mgmt_reg_addr(ra), .mgmt_wdata(wd));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, r,
        input logic [15:0] v, ex);
        host.xfer(w, a, r, v, d, ok);
        chk({15'h0, ok}, 16'h0001);
        if (!w) chk(d, ex);
    endtask
    task automatic t_energy;
        acc(0, 5'h05, 5'h11, 0, 16'h0002);
        acc(0, 5'h05, 5'h12, 0, 16'h0045);
        repeat (30) @(negedge clk);
        acc(0, 5'h05, 5'h11, 0, 16'h0000);
        acc(1, 5'h05, 5'h11, 16'hffff, 0);
        acc(0, 5'h05, 5'h11, 0, 16'h2001);
        energy_detect = 1'b1;
        repeat (6) @(negedge clk);
        acc(0, 5'h05, 5'h11, 0, 16'h2003);
        energy_detect = 1'b0;
        repeat (10) @(negedge clk);
        acc(0, 5'h05, 5'h11, 0, 16'h2003);
        repeat (20) @(negedge clk);
        acc(0, 5'h05, 5'h11, 0, 16'h2001);
        acc(1, 5'h05, 5'h11, 16'h0000, 0);
        acc(0, 5'h05, 5'h11, 0, 16'h0000);
    endtask
    task automatic t_mode;
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            acc(1, 5'h05, 5'h12, {8'hff, m, 5'h05}, 0);
            acc(0, 5'h05, 5'h12, 0, {8'h00, m, 5'h05});
            chk({12'h0, pd, an, s100, fd}, (m == 3'h6) ? 16'h0008 :
                (m == 3'h7) ? 16'h0004 : m[2] ? 16'h0 : {14'h0, m[1:0]});
            if (m == 3'h2 || m == 3'h3) chk({15'h0, crs}, {15'h0, !m[0]});
        end
    endtask
    task automatic t_addr;
        acc(1, 5'h05, 5'h12, 16'h004a, 0);
        host.xfer(0, 5'h05, 5'h11, 0, d, ok);
        chk({15'h0, ok}, 16'h0000);
        acc(0, 5'h0a, 5'h12, 0, 16'h004a);
        chk({5'h00, seed}, 16'h000a);
        acc(1, 5'h0a, 5'h00, 16'hffff, 0);
        acc(0, 5'h0a, 5'h00, 0, 16'h0000);
    endtask
    task automatic t_resets;
        @(negedge clk);
        {loader_we, loader_data} = {1'b1, 16'h00c3};
        @(negedge clk);
        loader_we = 1'b0;
        acc(0, 5'h03, 5'h12, 0, 16'h00c3);
        brst = 1'b1;
        @(negedge clk);
        brst = 1'b0;
        acc(0, 5'h03, 5'h12, 0, 16'h00c3);
        prst = 1'b1;
        @(negedge clk);
        prst = 1'b0;
        acc(0, 5'h05, 5'h12, 0, 16'h0045);
        chk({15'h0, lep}, 16'h0000);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        t_energy();
        t_mode();
        t_addr();
        t_resets();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: pmc_host.sv
// Purpose: Management host model issuing register accesses
// Assumes: One-cycle access strobe, answer one edge after it is taken
// Notes: Write data is inverted once the strobe is released
`default_nettype none
module pmc_host (
    input wire logic clk, // Clock
    input wire logic mgmt_ack, // Accepted
    input wire logic [15:0] mgmt_rdata, // Read data
    output logic mgmt_valid, // Strobe
    output logic mgmt_write, // Write flag
    output logic [4:0] mgmt_phy_addr, // Target address
    output logic [4:0] mgmt_reg_addr, // Register index
    output logic [15:0] mgmt_wdata // Write data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {mgmt_valid, mgmt_write, mgmt_phy_addr, mgmt_reg_addr} = 12'h000;
        mgmt_wdata = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [4:0] pa, ra,
        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        @(negedge clk);
        mgmt_valid = 1'b1;
        mgmt_write = w;
        mgmt_phy_addr = pa;
        mgmt_reg_addr = ra;
        mgmt_wdata = wd;
        // Taken at this edge; the answer stands for the following cycle
        @(posedge clk);
        @(negedge clk);
        ok = mgmt_ack;
        rd = mgmt_rdata;
        mgmt_valid = 1'b0;
        mgmt_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// File: pmc_pkg.sv
// Purpose: Shared constants for the PHY mode configuration registers
// Assumes: Management register access by 5-bit register index
// Notes: Register indices, field positions and mode codes live here; register reset values do not
`default_nettype none
package pmc_pkg;
    localparam logic [4:0] REG_ENERGY = 5'h11;
    localparam logic [4:0] REG_MODE = 5'h12;
    localparam int ENERGY_EN_BIT = 13;
    localparam int ENERGY_ON_BIT = 1;
    localparam int ENERGY_RSV_BIT = 0;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int ADDR_HI = 4;
    localparam int ADDR_LO = 0;
    localparam logic [2:0] MODE_10_HALF = 3'h0;
    localparam logic [2:0] MODE_10_FULL = 3'h1;
    localparam logic [2:0] MODE_100_HALF = 3'h2;
    localparam logic [2:0] MODE_100_FULL = 3'h3;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h6;
    localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7;
    localparam int ENERGY_IDLE_MS = 256;
    localparam int CLK_HZ = 10_000_000;
    localparam int ENERGY_IDLE_CYCLES = ENERGY_IDLE_MS * (CLK_HZ / 1000);
    localparam logic [15:0] ZERO16 = 16'h0000;
endpackage
`default_nettype wire

// File: pmc_regs.sv
// Purpose: Energy-detect control/status and PHY mode/address registers
// Assumes: Single clock; straps and energy detector arrive asynchronously
// Notes: Register access is a simple index/strobe management port
`default_nettype none

// Operation
// - Bit 13 enables energy-detect power-down, resets zero
// - Bit 1 reports valid line energy
// - Energy bit clears after 256 ms idle
// - Energy bit keeps soft reset, hard-resets one
// - Loader rewrites mode register after reset, reload
// - Bits 7:5 hold read/write PHY mode
// - 000 10M half, 001 10M full, no autoneg
// - 010 100M half, CRS on transmit and receive
// - 011 100M full, CRS on receive only
// - 110 power-down, 111 autoneg all; 100/101 reserved
// - Bits 4:0 address; answer only matching address
// - Address seeds the transmit scrambler key
// - Chip reset-control PHY reset restores mode, address
// - Basic-control PHY reset leaves mode, address alone
// - Autoneg strap one gives default mode 111
// - Otherwise default mode is 0, speed, duplex
// - Straps latched when chip reset releases
// - Default address comes from latched address strap
module pmc_regs #(
    parameter int IDLE_CYCLES = pmc_pkg::ENERGY_IDLE_CYCLES
) (
    input wire logic clk, // 10 MHz device clock
    input wire logic rst_b, // Chip-level hardware reset, sync, low
    input wire logic ce, // Clock enable; state frozen while low
    input wire logic port_reset_pulse, // Per-port reset via chip chip_reset_control_register
    input wire logic basic_ctrl_reset, // Reset via PHY basic control bit
    input wire logic autoneg_strap, // Auto-negotiation strap pin
    input wire logic speed_strap, // Speed strap pin
    input wire logic duplex_strap, // Duplex strap pin
    input wire logic [4:0] addr_strap, // Address-select strap value
    input wire logic energy_detect, // Raw valid-energy indication
    input wire logic loader_we, // EEPROM loader write strobe
    input wire logic [15:0] loader_data, // EEPROM loader mode register value
    input wire logic mgmt_valid, // Management access strobe
    input wire logic mgmt_write, // High for write, low for read
    input wire logic [4:0] mgmt_phy_addr, // PHY address of the access
    input wire logic [4:0] mgmt_reg_addr, // Register index of the access
    input wire logic [15:0] mgmt_wdata, // Write data
    output logic [15:0] mgmt_rdata, // Read data, registered
    output logic mgmt_ack, // One-cycle pulse: access accepted
    output logic energy_detect_powerdown_enable, // Power-down enable
    output logic line_energy_present, // Line energy status
    output logic [2:0] phy_mode, // Operating mode field
    output logic [4:0] phy_station_address, // Management address
    output logic autoneg_enable, // Decoded: auto-negotiation on
    output logic speed_100, // Decoded: 100 Mb/s forced
    output logic full_duplex, // Decoded: full duplex forced
    output logic crs_on_transmit, // Decoded: CRS also during transmit
    output logic power_down, // Decoded: PHY powered down
    output logic [10:0] scrambler_seed // Initial scrambler key
);
    // Synchronisers for pins; stage one feeds only stage two
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] next_sync1;
    logic [7:0] next_sync2;
    // Latched straps
    logic strap_taken;
    logic st_an;
    logic st_spd;
    logic st_dup;
    logic [4:0] st_addr;
    logic next_strap_taken;
    logic next_st_an;
    logic next_st_spd;
    logic next_st_dup;
    logic [4:0] next_st_addr;
    // Energy state
    logic [31:0] idle_cnt;
    logic [31:0] next_idle_cnt;
    logic next_energy;
    logic next_edpd;
    logic rsv_bit;
    logic next_rsv_bit;
    // Mode register
    logic [2:0] next_mode;
    logic [4:0] next_addr;
    logic [2:0] def_mode;
    // Bus outputs
    logic [15:0] next_rdata;
    logic next_ack;
    logic hit;
    // Decoded mode flags, next values
    logic next_an;
    logic next_spd;
    logic next_fdx;
    logic next_crs;
    logic next_pd;
    logic [10:0] next_seed;

    always_comb begin
        next_sync1 = {addr_strap, autoneg_strap, speed_strap, duplex_strap};
        next_sync1[7:3] = addr_strap;
        next_sync1[2] = autoneg_strap;
        next_sync1[1] = speed_strap;
        next_sync1[0] = duplex_strap;
        next_sync2 = sync1;
    end

    // Energy detector has its own two-stage synchroniser
    logic en_s1;
    logic en_s2;
    logic next_en_s1;
    logic next_en_s2;

    // Stage one is read by stage two only, to keep metastability contained
    always_comb begin
        next_en_s1 = energy_detect;
        next_en_s2 = en_s1;
    end

    // No reset on the synchronisers: they must flush the pins during reset
    // so that the strap latch sees settled values on its first edge
    always_ff @(posedge clk) begin
        if (ce) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            en_s1 <= next_en_s1;
            en_s2 <= next_en_s2;
        end
    end

    // Straps are caught on the first enabled edge after reset release
    always_comb begin
        next_strap_taken = 1'b1;
        next_st_an = st_an;
        next_st_spd = st_spd;
        next_st_dup = st_dup;
        next_st_addr = st_addr;
        if (!strap_taken) begin
            next_st_an = sync2[2];
            next_st_spd = sync2[1];
            next_st_dup = sync2[0];
            next_st_addr = sync2[7:3];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strap_taken <= 1'b0;
            st_an <= 1'b0;
            st_spd <= 1'b0;
            st_dup <= 1'b0;
            st_addr <= 5'h00;
        end else if (ce) begin
            strap_taken <= next_strap_taken;
            st_an <= next_st_an;
            st_spd <= next_st_spd;
            st_dup <= next_st_dup;
            st_addr <= next_st_addr;
        end
    end

    // Default mode while straps are being latched follows the live sample
    always_comb begin
        if (strap_taken ? st_an : sync2[2]) begin
            def_mode = pmc_pkg::MODE_ALL_CAPABLE;
        end else if (strap_taken) begin
            def_mode = {1'b0, st_spd, st_dup};
        end else begin
            def_mode = {1'b0, sync2[1], sync2[0]};
        end
    end

    assign hit = mgmt_valid && (mgmt_phy_addr == phy_station_address);

    // Energy control/status register
    always_comb begin
        next_edpd = energy_detect_powerdown_enable;
        next_rsv_bit = rsv_bit;
        next_idle_cnt = idle_cnt;
        next_energy = line_energy_present;
        if (hit && mgmt_write && mgmt_reg_addr == pmc_pkg::REG_ENERGY) begin
            next_edpd = mgmt_wdata[pmc_pkg::ENERGY_EN_BIT];
            next_rsv_bit = mgmt_wdata[pmc_pkg::ENERGY_RSV_BIT];
        end
        if (en_s2) begin
            next_energy = 1'b1;
            next_idle_cnt = 32'h0000_0000;
        end else if (idle_cnt >= 32'(IDLE_CYCLES - 1)) begin
            next_energy = 1'b0;
        end else begin
            next_idle_cnt = idle_cnt + 32'h0000_0001;
        end
    end

    // Soft resets leave this register alone; only rst_b touches it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            energy_detect_powerdown_enable <= 1'b0;
            rsv_bit <= 1'b0;
            line_energy_present <= 1'b1;
            idle_cnt <= 32'h0000_0000;
        end else if (ce) begin
            energy_detect_powerdown_enable <= next_edpd;
            rsv_bit <= next_rsv_bit;
            line_energy_present <= next_energy;
            idle_cnt <= next_idle_cnt;
        end
    end

    // Mode/address register: soft reset, then loader, then host write
    always_comb begin
        next_mode = phy_mode;
        next_addr = phy_station_address;
        if (!strap_taken || port_reset_pulse) begin
            next_mode = def_mode;
            next_addr = strap_taken ? st_addr : sync2[7:3];
        end else if (loader_we) begin
            next_mode = loader_data[pmc_pkg::MODE_HI:pmc_pkg::MODE_LO];
            next_addr = loader_data[pmc_pkg::ADDR_HI:pmc_pkg::ADDR_LO];
        end else if (hit && mgmt_write && mgmt_reg_addr == pmc_pkg::REG_MODE) begin
            next_mode = mgmt_wdata[pmc_pkg::MODE_HI:pmc_pkg::MODE_LO];
            next_addr = mgmt_wdata[pmc_pkg::ADDR_HI:pmc_pkg::ADDR_LO];
        end
        // A basic-control reset deliberately does nothing here
        if (basic_ctrl_reset && !port_reset_pulse && strap_taken &&
            !loader_we && !hit) begin
            next_mode = phy_mode;
            next_addr = phy_station_address;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phy_mode <= pmc_pkg::MODE_ALL_CAPABLE;
            phy_station_address <= 5'h00;
        end else if (ce) begin
            phy_mode <= next_mode;
            phy_station_address <= next_addr;
        end
    end

    // Mode decode; reserved codes decode as 000, forced 10M half with CRS on transmit.
    // Decoding the next value keeps the flags in step with the field,
    // at the cost of a deeper path from the write data.
    always_comb begin
        next_an = next_mode == pmc_pkg::MODE_ALL_CAPABLE;
        next_pd = next_mode == pmc_pkg::MODE_POWER_DOWN;
        next_spd = next_mode == pmc_pkg::MODE_100_HALF ||
                   next_mode == pmc_pkg::MODE_100_FULL;
        next_fdx = next_mode == pmc_pkg::MODE_10_FULL ||
                   next_mode == pmc_pkg::MODE_100_FULL;
        // Only forced 100M full keeps CRS quiet during transmit
        next_crs = next_mode != pmc_pkg::MODE_100_FULL;
        next_seed = {6'h00, next_addr};
    end

    // Reset values match the decode of the reset mode 111
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            autoneg_enable <= 1'b1;
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            crs_on_transmit <= 1'b1;
            power_down <= 1'b0;
            scrambler_seed <= 11'h000;
        end else if (ce) begin
            autoneg_enable <= next_an;
            power_down <= next_pd;
            speed_100 <= next_spd;
            full_duplex <= next_fdx;
            crs_on_transmit <= next_crs;
            scrambler_seed <= next_seed;
        end
    end

    // Read path, one-cycle registered answer
    always_comb begin
        next_rdata = pmc_pkg::ZERO16;
        next_ack = hit;
        if (hit && !mgmt_write) begin
            if (mgmt_reg_addr == pmc_pkg::REG_ENERGY) begin
                next_rdata[pmc_pkg::ENERGY_EN_BIT] = energy_detect_powerdown_enable;
                next_rdata[pmc_pkg::ENERGY_ON_BIT] = line_energy_present;
                next_rdata[pmc_pkg::ENERGY_RSV_BIT] = rsv_bit;
            end else if (mgmt_reg_addr == pmc_pkg::REG_MODE) begin
                next_rdata[pmc_pkg::MODE_HI:pmc_pkg::MODE_LO] = phy_mode;
                next_rdata[pmc_pkg::ADDR_HI:pmc_pkg::ADDR_LO] = phy_station_address;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mgmt_rdata <= 16'h0000;
            mgmt_ack <= 1'b0;
        end else if (ce) begin
            mgmt_rdata <= next_rdata;
            mgmt_ack <= next_ack;
        end
    end
endmodule
`default_nettype wire

// File: pmc_regs_checker.sv
// Purpose: Port-level assertions for the PHY mode configuration registers
// Assumes: Straps stay stable while the checker runs
// Notes: Bound into every pmc_regs instance
`default_nettype none
module pmc_regs_checker (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, low
    input wire logic ce, // Clock enable
    input wire logic port_reset_pulse, // Per-port reset
    input wire logic basic_ctrl_reset, // Basic-control reset
    input wire logic autoneg_strap, // Strap
    input wire logic speed_strap, // Strap
    input wire logic duplex_strap, // Strap
    input wire logic [4:0] addr_strap, // Strap
    input wire logic energy_detect, // Raw energy
    input wire logic loader_we, // Loader strobe
    input wire logic mgmt_valid, // Access strobe
    input wire logic mgmt_write, // Write flag
    input wire logic [4:0] mgmt_phy_addr, // Access address
    input wire logic [4:0] mgmt_reg_addr, // Register index
    input wire logic [15:0] mgmt_rdata, // Read data
    input wire logic mgmt_ack, // Accepted
    input wire logic energy_detect_powerdown_enable, // Power-down enable
    input wire logic line_energy_present, // Energy status
    input wire logic [2:0] phy_mode, // Mode
    input wire logic [4:0] phy_station_address, // Address
    input wire logic autoneg_enable, // Decoded
    input wire logic speed_100, // Decoded
    input wire logic full_duplex, // Decoded
    input wire logic power_down, // Decoded
    input wire logic [10:0] scrambler_seed // Seed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ack;
        ce && mgmt_valid && mgmt_phy_addr == phy_station_address
            |=> mgmt_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_no_ack;
        ce && !(mgmt_valid && mgmt_phy_addr == phy_station_address)
            |=> !mgmt_ack;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    property p_rd_energy;
        $past(mgmt_valid && !mgmt_write && mgmt_reg_addr == 5'h11
            && mgmt_phy_addr == phy_station_address) |-> mgmt_rdata[15:14]
            == 2'h0 && mgmt_rdata[12:2] == 11'h000
            && mgmt_rdata[13] == energy_detect_powerdown_enable;
    endproperty
    a_rd_energy: assert property (p_rd_energy) else $error("rd 11");
    property p_rd_mode;
        $past(mgmt_valid && !mgmt_write && mgmt_reg_addr == 5'h12
            && mgmt_phy_addr == phy_station_address)
            |-> mgmt_rdata == {8'h00, phy_mode, phy_station_address};
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("rd 12");
    property p_dec_lo;
        $past(rst_b) && !phy_mode[2] |-> speed_100 == phy_mode[1]
            && full_duplex == phy_mode[0] && !autoneg_enable && !power_down;
    endproperty
    a_dec_lo: assert property (p_dec_lo) else $error("dec");
    property p_dec_hi;
        $past(rst_b) |-> power_down == (phy_mode == 3'h6)
            && autoneg_enable == (phy_mode == 3'h7);
    endproperty
    a_dec_hi: assert property (p_dec_hi) else $error("dec hi");
    property p_seed;
        $past(rst_b) |-> scrambler_seed == {6'h00, phy_station_address};
    endproperty
    a_seed: assert property (p_seed) else $error("seed");
    property p_energy_on;
        energy_detect [*4] |-> line_energy_present;
    endproperty
    a_energy_on: assert property (p_energy_on) else $error("energy");
    property p_port_rst;
        port_reset_pulse |=> phy_station_address == addr_strap && phy_mode
            == (autoneg_strap ? 3'h7 : {1'b0, speed_strap, duplex_strap});
    endproperty
    a_port_rst: assert property (p_port_rst) else $error("port rst");
    property p_basic_rst;
        basic_ctrl_reset && !loader_we && !mgmt_valid && !port_reset_pulse
            |=> $stable({phy_mode, phy_station_address});
    endproperty
    a_basic_rst: assert property (p_basic_rst) else $error("basic");
endmodule
bind pmc_regs pmc_regs_checker u_chk (.*);
`default_nettype wire
